// File: verilog/shift_count_regs.svh
// constants for the shift iteration counter
// Functional notes
// - eight data bits plus one parity bit
// - holds shift, multiply, normalize counts
// - decrement loads exponent sum bits 0-7
// - fault test loads source bits 16-23
// - shift decode copies bits 18-20 to 1-3
// - forced iteration constants into bits 1-6
// - count feeds adder, result written back
// - bits 0-5 drive count decoder
// - convert drives count onto address 24-27
// - adder input wins only when alone
// - locks when release pair goes idle
`ifndef SHIFT_COUNT_REGS_SVH
`define SHIFT_COUNT_REGS_SVH
`define COUNT_RESET_VALUE 8'h00
`define COUNT_RESET_PARITY 1'b1
`define COUNT_SCAN_WORD 4'hc
`define COUNT_SCAN_PULSE 2'h2
`define COUNT_SHIFT_LSB 1
`define COUNT_FORCE_LSB 1
`define COUNT_DECODE_LSB 0
`define COUNT_ADDR_LSB 4
`endif

// File: verilog/shift_count_pkg.sv
// types for the shift iteration counter
package shift_count_pkg;
    typedef struct packed {
        logic [7:0] value;
        logic parity;
    } count_word_t;
    typedef enum logic [4:0] {
        SRC_NONE = 5'h01,
        SRC_SUM = 5'h02,
        SRC_SCAN = 5'h04,
        SRC_SHIFT = 5'h08,
        SRC_FORCE = 5'h10
    } load_src_t;
endpackage

// File: verilog/shift_iteration_counter.sv
// shift / iteration count register with its load gating and outputs
`timescale 1ns/1ps
`include "shift_count_regs.svh"
module shift_iteration_counter
#(
    // widths of the count and of the two partial load fields
    parameter int COUNT_BITS = 8,
    parameter int SHIFT_BITS = 3,
    parameter int FORCE_BITS = 6
)
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic clkEn,
    // release pair, true and complement
    input wire logic releaseHi,
    input wire logic releaseLo_b,
    // load sources
    input wire logic sumLoad,
    input wire logic [7:0] exponentSumBus,
    input wire logic faultLocateTest,
    input wire logic [3:0] scanWord,
    input wire logic [1:0] scanPulse,
    input wire logic [7:0] sourceScanBits,
    input wire logic shiftDecode,
    input wire logic [2:0] shiftField,
    input wire logic forceLoad,
    input wire logic [5:0] forcedCountBits,
    // output gating
    input wire logic convertVfl,
    // outputs
    output shift_count_pkg::count_word_t countOut,
    output logic [5:0] decoderIn,
    output logic [3:0] addrNibble,
    output logic addrNibbleValid
);
    ////////////////////////////////////////////////////////////////
    logic releaseActive;
    logic scanLoad;
    shift_count_pkg::load_src_t loadSrc;
    logic [7:0] next_value;
    shift_count_pkg::count_word_t count;
    logic [7:0] shiftImage;
    logic [7:0] forceImage;

    ////////////////////////////////////////////////////////////////
    // ports and the packed word are fixed at eight bits; refuse other sizes
    if (COUNT_BITS != 8)
    begin : g_bad_count
        $error("count width must be 8");
    end
    if (SHIFT_BITS != 3 || `COUNT_SHIFT_LSB + SHIFT_BITS > COUNT_BITS)
    begin : g_bad_shift
        $error("shift field must be 3 bits inside the count");
    end
    if (FORCE_BITS != 6 || `COUNT_FORCE_LSB + FORCE_BITS > COUNT_BITS)
    begin : g_bad_force
        $error("forced field must be 6 bits inside the count");
    end

    // odd parity over value and parity bit; shared by the register and its check
    function automatic logic oddParity(input logic [7:0] value);
        oddParity = ~^value;
    endfunction

    ////////////////////////////////////////////////////////////////
    // zero-filled images of the partial loads, one bit per pass
    // bits outside a field are cleared, not kept: no stale count survives
    for (genvar b = 0; b < COUNT_BITS; b++)
    begin : g_image
        if (b >= `COUNT_SHIFT_LSB && b < `COUNT_SHIFT_LSB + SHIFT_BITS)
        begin : g_shift_in
            assign shiftImage[b] = shiftField[b - `COUNT_SHIFT_LSB];
        end
        else
        begin : g_shift_out
            assign shiftImage[b] = 1'b0;
        end
        if (b >= `COUNT_FORCE_LSB && b < `COUNT_FORCE_LSB + FORCE_BITS)
        begin : g_force_in
            assign forceImage[b] = forcedCountBits[b - `COUNT_FORCE_LSB];
        end
        else
        begin : g_force_out
            assign forceImage[b] = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////
    // both lines must agree; a half-switched pair keeps the latch closed
    assign releaseActive = releaseHi && !releaseLo_b;
    assign scanLoad = faultLocateTest && scanWord == `COUNT_SCAN_WORD
        && scanPulse == `COUNT_SCAN_PULSE;

    // priority: scan, force, shift decode, then adder sum
    always_comb
    begin
        loadSrc = shift_count_pkg::SRC_NONE;
        if (releaseActive)
        begin
            if (scanLoad)
                loadSrc = shift_count_pkg::SRC_SCAN;
            else if (forceLoad)
                loadSrc = shift_count_pkg::SRC_FORCE;
            else if (shiftDecode)
                loadSrc = shift_count_pkg::SRC_SHIFT;
            else if (sumLoad)
                loadSrc = shift_count_pkg::SRC_SUM;
        end
    end

    always_comb
    begin
        next_value = count.value;
        unique case (loadSrc)
            shift_count_pkg::SRC_NONE: next_value = count.value;
            shift_count_pkg::SRC_SUM: next_value = exponentSumBus;
            shift_count_pkg::SRC_SCAN: next_value = sourceScanBits;
            shift_count_pkg::SRC_SHIFT: next_value = shiftImage;
            shift_count_pkg::SRC_FORCE: next_value = forceImage;
            default: next_value = count.value;
        endcase
    end

    ////////////////////////////////////////////////////////////////
    // single holder for every kind of count
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            count.value <= `COUNT_RESET_VALUE;
            count.parity <= `COUNT_RESET_PARITY;
        end
        else if (clkEn)
        begin
            count.value <= next_value;
            count.parity <= oddParity(next_value);
        end
    end

    ////////////////////////////////////////////////////////////////
    // outputs registered one cycle behind the count
    // costs a cycle of latency but keeps every output straight off a flop

    // feed to the adder true/complement input
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            countOut <= '{value: `COUNT_RESET_VALUE, parity: `COUNT_RESET_PARITY};
        end
        else if (clkEn)
        begin
            countOut <= count;
        end
    end

    // feed to the count decoder
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            decoderIn <= 6'h00;
        end
        else if (clkEn)
        begin
            decoderIn <= count.value[`COUNT_DECODE_LSB+5 -: 6];
        end
    end

    // feed to the addressing adder, only during a variable length convert
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            addrNibble <= 4'h0;
            addrNibbleValid <= 1'b0;
        end
        else if (clkEn)
        begin
            addrNibble <= convertVfl ? count.value[`COUNT_ADDR_LSB-1 -: 4] : 4'h0;
            addrNibbleValid <= convertVfl;
        end
    end

    ////////////////////////////////////////////////////////////////
    chk_parity_odd: assert property (@(posedge mclk) disable iff (!rst_b)
        count.parity == oddParity(count.value)) else $error("count parity wrong");
    chk_hold_idle: assert property (@(posedge mclk) disable iff (!rst_b)
        !releaseActive |=> $stable(count)) else $error("count moved while locked");
    chk_sum_load: assert property (@(posedge mclk) disable iff (!rst_b)
        clkEn && releaseActive && sumLoad && !scanLoad && !forceLoad && !shiftDecode
        |=> count.value == $past(exponentSumBus)) else $error("sum not loaded");
    chk_scan_load: assert property (@(posedge mclk) disable iff (!rst_b)
        clkEn && releaseActive && scanLoad |=> count.value == $past(sourceScanBits))
        else $error("scan not loaded");
    chk_shift_field: assert property (@(posedge mclk) disable iff (!rst_b)
        clkEn && releaseActive && shiftDecode && !scanLoad && !forceLoad
        |=> count.value[3:1] == $past(shiftField)) else $error("shift field wrong");
    chk_force_bits: assert property (@(posedge mclk) disable iff (!rst_b)
        clkEn && releaseActive && forceLoad && !scanLoad
        |=> count.value[6:1] == $past(forcedCountBits)) else $error("force wrong");
    chk_decode_out: assert property (@(posedge mclk) disable iff (!rst_b)
        clkEn |=> decoderIn == $past(count.value[5:0])) else $error("decoder feed wrong");
    chk_addr_gate: assert property (@(posedge mclk) disable iff (!rst_b)
        clkEn && !convertVfl |=> addrNibble == 4'h0 && !addrNibbleValid)
        else $error("address nibble leaked");

    chk_addr_copy: assert property (@(posedge mclk) disable iff (!rst_b)
        clkEn && convertVfl |=> addrNibble == $past(count.value[3:0]) && addrNibbleValid)
        else $error("address nibble wrong");
    chk_out_copy: assert property (@(posedge mclk) disable iff (!rst_b)
        clkEn |=> countOut == $past(count)) else $error("adder feed wrong");

    chk_shift_clear: assert property (@(posedge mclk) disable iff (!rst_b)
        clkEn && releaseActive && shiftDecode && !scanLoad && !forceLoad
        |=> count.value[7:4] == 4'h0 && count.value[0] == 1'b0)
        else $error("shift load left stale bits");
    chk_force_clear: assert property (@(posedge mclk) disable iff (!rst_b)
        clkEn && releaseActive && forceLoad && !scanLoad
        |=> count.value[7] == 1'b0 && count.value[0] == 1'b0)
        else $error("force load left stale bits");

    // a low enable must freeze the count, countOut and addrNibble
    chk_freeze_all: assert property (@(posedge mclk) disable iff (!rst_b)
        !clkEn |=> $stable(count) && $stable(countOut) && $stable(addrNibble))
        else $error("state moved while frozen");
endmodule

// File: verif/exponent_adder_model.sv
// behavioural exponent adder that decrements the count it is fed
`timescale 1ns/1ps
module exponent_adder_model
(
    // count from the register, true input
    input wire logic [7:0] countIn,
    // sum back to the register
    output logic [7:0] sumOut
);
    // one iteration step per pass; purely combinational like the real adder
    assign sumOut = countIn - 8'h01;
endmodule

// File: verif/shift_iteration_counter_tb_top.sv
// self-checking bench for the shift iteration counter
`timescale 1ns/1ps
module shift_iteration_counter_tb_top;
    logic mclk = 1'b0, rst_b = 1'b0, releaseHi = 1'b0, releaseLo_b = 1'b1;
    logic sumLoad = 1'b0, faultLocateTest = 1'b0, shiftDecode = 1'b0;
    logic forceLoad = 1'b0, convertVfl = 1'b0, clkEn = 1'b1;
    logic [3:0] scanWord = 4'h0, addrNibble;
    logic [1:0] scanPulse = 2'h0;
    logic [7:0] sourceScanBits = 8'h00, sumBus;
    logic [2:0] shiftField = 3'h0;
    logic [5:0] forcedCountBits = 6'h00, decoderIn;
    logic addrNibbleValid;
    shift_count_pkg::count_word_t cnt;
    int nFail = 0, checkCount = 0, cyc = 0;
    ////////////////////////////////////////////////////////////
    shift_iteration_counter dut (.mclk(mclk), .rst_b(rst_b), .clkEn(clkEn),
        .releaseHi(releaseHi), .releaseLo_b(releaseLo_b), .sumLoad(sumLoad),
        .exponentSumBus(sumBus), .faultLocateTest(faultLocateTest),
        .scanWord(scanWord), .scanPulse(scanPulse), .sourceScanBits(sourceScanBits),
        .shiftDecode(shiftDecode), .shiftField(shiftField), .forceLoad(forceLoad),
        .forcedCountBits(forcedCountBits), .convertVfl(convertVfl), .countOut(cnt),
        .decoderIn(decoderIn), .addrNibble(addrNibble), .addrNibbleValid(addrNibbleValid));
    exponent_adder_model partner (.countIn(cnt.value), .sumOut(sumBus));
    initial forever #25 mclk = ~mclk;
    ////////////////////////////////////////////////////////////
    task closeOut;
        begin
            if (nFail == 0 && checkCount > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    // s = {scan, force, shift, sum}; release drops after one edge
    task ld(input logic [3:0] s, input logic h, input logic lb);
        begin
            @(negedge mclk);
            {faultLocateTest, forceLoad, shiftDecode, sumLoad} = s;
            releaseHi = h;
            releaseLo_b = lb;
            @(negedge mclk);
            {faultLocateTest, forceLoad, shiftDecode, sumLoad} = 4'h0;
            releaseHi = 1'b0;
            releaseLo_b = 1'b1;
            @(negedge mclk);
        end
    endtask
    task chk(input logic [7:0] v, input logic cv);
        logic [19:0] e;
        begin
            e = {v, ~^v, v[5:0], cv ? v[3:0] : 4'h0, cv};
            checkCount++;
            if ({cnt, decoderIn, addrNibble, addrNibbleValid} !== e)
            begin
                nFail++;
                $display("CHECK FAILED outputs exp %h got %h", e,
                    {cnt, decoderIn, addrNibble, addrNibbleValid});
            end
        end
    endtask
    // hang guard: the sequence needs well under 200 cycles
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            nFail++;
            closeOut();
        end
    end
    initial
    begin
        repeat (16) @(posedge mclk);
        @(negedge mclk);
        rst_b = 1'b1;
        chk(8'h00, 1'b0);
        scanWord = 4'hc;
        scanPulse = 2'h1;
        sourceScanBits = 8'ha5;
        ld(4'h8, 1'b1, 1'b0); chk(8'h00, 1'b0);
        scanPulse = 2'h2;
        ld(4'h9, 1'b1, 1'b0); chk(8'ha5, 1'b0);
        forcedCountBits = 6'h2b;
        ld(4'h5, 1'b1, 1'b0); chk(8'h56, 1'b0);
        shiftField = 3'h5;
        ld(4'h2, 1'b1, 1'b0); chk(8'h0a, 1'b0);
        ld(4'h1, 1'b0, 1'b0); chk(8'h0a, 1'b0);
        ld(4'h1, 1'b1, 1'b1); chk(8'h0a, 1'b0);
        convertVfl = 1'b1;
        ld(4'h1, 1'b1, 1'b0); chk(8'h09, 1'b1);
        ld(4'h1, 1'b1, 1'b0); chk(8'h08, 1'b1);
        clkEn = 1'b0;
        ld(4'h1, 1'b1, 1'b0); chk(8'h08, 1'b1);
        clkEn = 1'b1;
        convertVfl = 1'b0;
        ld(4'h1, 1'b1, 1'b0); chk(8'h07, 1'b0);
        closeOut();
    end
endmodule
